// File: hw/nfsf_formatter.sv
`timescale 1ns/10ps
// Summary of operation
// - checksum is XOR of characters between dollar and asterisk, two hex.
// - time sent as hhmmss.sss, six digits, point, three digits.
// - latitude ddmm.mmmm, longitude dddmm.mmmm, leading zeros always sent.
// - latitude followed by N for north, S for south.
// - longitude followed by E for east, W for west.
// - fix quality digit 0 none, 1 standard, 2 differential.
// - satellites used as two digits, 00 to 16.
// - horizontal dilution two digits, point, one digit, 00.0 to 99.9.
// - altitude in metres, one fraction digit, then unit M.
// - geoid and age fields empty, station field carries no station.
// - fix-data order time, position, quality, sats, dilution, altitude.
// - lat/lon order position, time, status, mode, checksum.
// - lat/lon status A when valid, V when not.
// - lat/lon mode A autonomous, V when not valid.
// - low reset input resets; left undriven it reads high.
// - boot select high or open runs flash, low runs ROM.
// - time mark output pulses once each second.
// - serial link 115200 baud, eight data bits, no parity, one stop.
// - fix-data on by default, lat/lon sentence off by default.
module nfsf_formatter #(
   parameter int PPS_PERIOD_CYC = nfsf_pkg::PPS_PERIOD_CYC,
   parameter int PPS_HIGH_CYC   = nfsf_pkg::PPS_HIGH_CYC,
   parameter int BIT_CYC        = nfsf_pkg::BIT_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   input  wire logic        boot_rom_n,
   output      logic        run_from_rom,
   output      logic        second_time_mark_out,
   output      logic        uart_txd
);
   localparam int PW = $clog2(PPS_PERIOD_CYC);
   localparam int BW = nfsf_pkg::GGA_LEN * 8;
   localparam int PAD_W = (nfsf_pkg::GGA_LEN - nfsf_pkg::GLL_LEN) * 8;

   logic [nfsf_pkg::CTRL_W-1:0] ctrl_ff;
   nfsf_pkg::nfsf_fix_t         fix_ff;
   nfsf_pkg::nfsf_fix_t         snap_ff;
   nfsf_pkg::nfsf_state_t       state_ff;
   logic [6:0]  idx_ff;
   logic [2:0]  tix_ff;
   logic [7:0]  csum_ff;
   logic        sel_gll_ff;
   logic        pend_gll_ff;
   logic [7:0]  sent_cnt_ff;
   logic [PW-1:0] pps_cnt_ff;
   logic        pps_tick;
   logic        mark_ff;
   logic        boot_meta_ff;
   logic        boot_sync_ff;
   logic        rom_ff;
   logic        wr_en;
   logic        go_pulse;
   logic        trigger;
   logic [1:0]  en_now;
   logic [BW-1:0] gga_body;
   logic [BW-1:0] gll_body;
   logic [BW-1:0] body;
   logic [7:0]  body_ch;
   logic [7:0]  tail_ch;
   logic [7:0]  tx_data;
   logic        tx_valid;
   logic        tx_ready;
   logic        tx_take;
   logic        body_last;
   logic [6:0]  body_len;

   // one decimal digit as an ascii character
   function automatic logic [7:0] dig(input logic [3:0] d);
      return {4'h3, d};
   endfunction : dig

   // upper-case hexadecimal character
   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n < 4'hA) ? {4'h3, n} : (8'h37 + {4'h0, n});
   endfunction : hexc

   function automatic logic [79:0] time_str(input logic [23:0] h,
                                            input logic [11:0] m);
      return {dig(h[23:20]), dig(h[19:16]), dig(h[15:12]),
              dig(h[11:8]), dig(h[7:4]), dig(h[3:0]), ".",
              dig(m[11:8]), dig(m[7:4]), dig(m[3:0])};
   endfunction : time_str

   function automatic logic [71:0] lat_str(input logic [31:0] v);
      return {dig(v[31:28]), dig(v[27:24]), dig(v[23:20]),
              dig(v[19:16]), ".", dig(v[15:12]), dig(v[11:8]),
              dig(v[7:4]), dig(v[3:0])};
   endfunction : lat_str

   function automatic logic [79:0] lon_str(input logic [35:0] v);
      return {dig(v[35:32]), lat_str(v[31:0])};
   endfunction : lon_str

   // altitude with sign and leading zeros squeezed out
   function automatic logic [63:0] alt_str(input logic        neg,
                                           input logic [23:0] a);
      logic [7:0] c4;
      logic [7:0] c3;
      logic [7:0] c2;
      logic [7:0] c1;
      c4 = (a[23:20] == 4'h0) ? nfsf_pkg::CH_SKIP : dig(a[23:20]);
      c3 = (a[23:16] == 8'h00) ? nfsf_pkg::CH_SKIP : dig(a[19:16]);
      c2 = (a[23:12] == 12'h000) ? nfsf_pkg::CH_SKIP : dig(a[15:12]);
      c1 = (a[23:8] == 16'h0000) ? nfsf_pkg::CH_SKIP : dig(a[11:8]);
      return {neg ? nfsf_pkg::CH_MINUS : nfsf_pkg::CH_SKIP,
              c4, c3, c2, c1, dig(a[7:4]), ".", dig(a[3:0])};
   endfunction : alt_str

   // APB: zero wait states, every access completes in its access phase
   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign pslverr = psel & penable & (paddr > nfsf_pkg::ADDR_STATUS
                                      || paddr[1:0] != 2'b00);

   // read data is registered at setup so it stands through access
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         case (paddr)
            nfsf_pkg::ADDR_CTRL:   prdata <= {23'h0, ctrl_ff};
            nfsf_pkg::ADDR_TIME:   prdata <= {8'h00, fix_ff.hms};
            nfsf_pkg::ADDR_MSEC:   prdata <= {20'h0, fix_ff.msec};
            nfsf_pkg::ADDR_LAT:    prdata <= fix_ff.lat;
            nfsf_pkg::ADDR_LON:    prdata <= fix_ff.lon[31:0];
            nfsf_pkg::ADDR_INFO:   prdata <= {3'h0, fix_ff.valid,
                                      fix_ff.hdop, fix_ff.sats,
                                      fix_ff.qual, fix_ff.west,
                                      fix_ff.south, fix_ff.lon[35:32]};
            nfsf_pkg::ADDR_ALT:    prdata <= {7'h0, fix_ff.alt_neg,
                                              fix_ff.alt};
            nfsf_pkg::ADDR_STATUS: prdata <= {16'h0, sent_cnt_ff, 6'h0,
                                      rom_ff, state_ff != nfsf_pkg::ST_IDLE};
            default:               prdata <= 32'h0000_0000;
         endcase
      end
   end

   // control with fix-data on, lat/lon off after reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_ff <= nfsf_pkg::CTRL_RST;
      end else if (wr_en && paddr == nfsf_pkg::ADDR_CTRL) begin
         ctrl_ff <= pwdata[nfsf_pkg::CTRL_W-1:0] & ~9'h008;
      end
   end
   assign go_pulse = wr_en && paddr == nfsf_pkg::ADDR_CTRL
                     && pwdata[nfsf_pkg::CTRL_GO];
   assign en_now = go_pulse ? pwdata[1:0] : ctrl_ff[1:0]; // go uses new ones

   // live fix registers, software rewrites them freely
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         fix_ff <= '0;
      end else if (wr_en) begin
         case (paddr)
            nfsf_pkg::ADDR_TIME: fix_ff.hms <= pwdata[23:0];
            nfsf_pkg::ADDR_MSEC: fix_ff.msec <= pwdata[11:0];
            nfsf_pkg::ADDR_LAT:  fix_ff.lat <= pwdata;
            nfsf_pkg::ADDR_LON:  fix_ff.lon[31:0] <= pwdata;
            nfsf_pkg::ADDR_INFO: begin
               fix_ff.lon[35:32] <= pwdata[3:0];
               fix_ff.south <= pwdata[nfsf_pkg::INFO_SOUTH];
               fix_ff.west  <= pwdata[nfsf_pkg::INFO_WEST];
               fix_ff.qual  <= pwdata[nfsf_pkg::INFO_QUAL +: 2];
               fix_ff.sats  <= pwdata[nfsf_pkg::INFO_SATS +: 8];
               fix_ff.hdop  <= pwdata[nfsf_pkg::INFO_HDOP +: 12];
               fix_ff.valid <= pwdata[nfsf_pkg::INFO_VALID];
            end
            nfsf_pkg::ADDR_ALT: begin
               fix_ff.alt     <= pwdata[23:0];
               fix_ff.alt_neg <= pwdata[nfsf_pkg::ALT_NEG];
            end
            default: ;
         endcase
      end
   end

   // boot strap synchronised, low selects ROM
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         boot_meta_ff <= 1'b1;
         boot_sync_ff <= 1'b1;
         rom_ff       <= 1'b0;
      end else begin
         boot_meta_ff <= boot_rom_n;
         boot_sync_ff <= boot_meta_ff;
         rom_ff       <= ~boot_sync_ff;
      end
   end
   assign run_from_rom = rom_ff;

   // one-second time mark, pulse high at start of second
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pps_cnt_ff <= '0;
         mark_ff    <= 1'b0;
      end else begin
         pps_cnt_ff <= pps_tick ? '0 : pps_cnt_ff + PW'(1);
         mark_ff    <= pps_tick | (pps_cnt_ff < PW'(PPS_HIGH_CYC - 1));
      end
   end
   assign pps_tick = (pps_cnt_ff == PW'(PPS_PERIOD_CYC - 1));
   assign second_time_mark_out = mark_ff;

   // an update comes from software or from each second mark
   assign trigger = go_pulse | (ctrl_ff[nfsf_pkg::CTRL_AUTO] & pps_tick);

   always_comb begin
      gga_body = {"$GPGGA,", time_str(snap_ff.hms, snap_ff.msec), ",",
         lat_str(snap_ff.lat), ",",
         snap_ff.south ? nfsf_pkg::CH_S : nfsf_pkg::CH_N, ",",
         lon_str(snap_ff.lon), ",",
         snap_ff.west ? nfsf_pkg::CH_W : nfsf_pkg::CH_E, ",",
         // quality digit, unknown code reads as no fix
         (snap_ff.qual == 2'b11) ? nfsf_pkg::CH_ZERO
                                 : dig({2'b00, snap_ff.qual}), ",",
         (snap_ff.sats > nfsf_pkg::SATS_MAX)
            ? {dig(4'h1), dig(4'h6)}
            : {dig(snap_ff.sats[7:4]), dig(snap_ff.sats[3:0])}, ",",
         // dilution, two digits, point, one digit
         dig(snap_ff.hdop[11:8]), dig(snap_ff.hdop[7:4]), ".",
         dig(snap_ff.hdop[3:0]), ",",
         alt_str(snap_ff.alt_neg, snap_ff.alt),
         // unit, empty geoid and age, null station
         ",M,,,,", "0000"};
   end

   always_comb begin
      gll_body = {"$GPGLL,", lat_str(snap_ff.lat), ",",
         snap_ff.south ? nfsf_pkg::CH_S : nfsf_pkg::CH_N, ",",
         lon_str(snap_ff.lon), ",",
         snap_ff.west ? nfsf_pkg::CH_W : nfsf_pkg::CH_E, ",",
         time_str(snap_ff.hms, snap_ff.msec), ",",
         snap_ff.valid ? nfsf_pkg::CH_A : nfsf_pkg::CH_V, ",",
         snap_ff.valid ? nfsf_pkg::CH_A : nfsf_pkg::CH_V,
         {PAD_W{1'b0}}};
   end

   assign body     = sel_gll_ff ? gll_body : gga_body;
   assign body_len = sel_gll_ff ? 7'(nfsf_pkg::GLL_LEN)
                                : 7'(nfsf_pkg::GGA_LEN);
   assign body_ch  = body[(nfsf_pkg::GGA_LEN - 1 - idx_ff) * 8 +: 8];
   assign body_last = (idx_ff == body_len - 7'h01);

   always_comb begin
      case (tix_ff)
         3'h0:    tail_ch = nfsf_pkg::CH_STAR;
         3'h1:    tail_ch = hexc(csum_ff[7:4]);
         3'h2:    tail_ch = hexc(csum_ff[3:0]);
         3'h3:    tail_ch = nfsf_pkg::CH_CR;
         default: tail_ch = nfsf_pkg::CH_LF;
      endcase
   end

   // skipped altitude characters never reach the line
   assign tx_valid = (state_ff == nfsf_pkg::ST_TAIL) ||
                     (state_ff == nfsf_pkg::ST_BODY &&
                      body_ch != nfsf_pkg::CH_SKIP);
   assign tx_data  = (state_ff == nfsf_pkg::ST_TAIL) ? tail_ch : body_ch;
   assign tx_take  = tx_valid & tx_ready;

   // snapshot keeps one sentence pair coherent while software updates
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         snap_ff <= '0;
      end else if (state_ff == nfsf_pkg::ST_IDLE && trigger) begin
         snap_ff <= fix_ff;
      end
   end

   // sequencer, fix-data first then lat/lon, back to back
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_ff    <= nfsf_pkg::ST_IDLE;
         idx_ff      <= 7'h00;
         tix_ff      <= 3'h0;
         sel_gll_ff  <= 1'b0;
         pend_gll_ff <= 1'b0;
         sent_cnt_ff <= 8'h00;
      end else begin
         case (state_ff)
            nfsf_pkg::ST_IDLE: begin
               if (trigger && en_now != 2'b00) begin
                  state_ff    <= nfsf_pkg::ST_BODY;
                  idx_ff      <= 7'h00;
                  sel_gll_ff  <= ~en_now[nfsf_pkg::CTRL_GGA_EN];
                  pend_gll_ff <= &en_now;
               end
            end
            nfsf_pkg::ST_BODY: begin
               if (!tx_valid || tx_ready) begin
                  idx_ff <= idx_ff + 7'h01;
                  if (body_last) begin
                     state_ff <= nfsf_pkg::ST_TAIL;
                     tix_ff   <= 3'h0;
                  end
               end
            end
            nfsf_pkg::ST_TAIL: begin
               if (tx_ready) begin
                  tix_ff <= tix_ff + 3'h1;
                  if (tix_ff == 3'(nfsf_pkg::TAIL_LEN - 1)) begin
                     sent_cnt_ff <= sent_cnt_ff + 8'h01;
                     idx_ff      <= 7'h00;
                     if (pend_gll_ff) begin
                        pend_gll_ff <= 1'b0;
                        sel_gll_ff  <= 1'b1;
                        state_ff    <= nfsf_pkg::ST_BODY;
                     end else begin
                        state_ff <= nfsf_pkg::ST_IDLE;
                     end
                  end
               end
            end
            default: state_ff <= nfsf_pkg::ST_IDLE;
         endcase
      end
   end

   // running XOR, the leading dollar sign left out
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         csum_ff <= 8'h00;
      end else if (state_ff != nfsf_pkg::ST_BODY) begin
         if (state_ff == nfsf_pkg::ST_IDLE || tix_ff ==
             3'(nfsf_pkg::TAIL_LEN - 1)) begin
            csum_ff <= 8'h00;
         end
      end else if (tx_take && idx_ff != 7'h00) begin
         csum_ff <= csum_ff ^ body_ch;
      end
   end

   nfsf_uart_tx #(
      .BIT_CYC (BIT_CYC)
   ) u_tx (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .tx_valid (tx_valid),
      .tx_data  (tx_data),
      .tx_ready (tx_ready),
      .txd      (uart_txd)
   );
   // nrst is the low-active reset pin; board pull-up when open
endmodule : nfsf_formatter

// File: hw/nfsf_pkg.sv
package nfsf_pkg;
   // clock, serial link and time mark timing
   localparam int CLK_HZ          = 125_000_000;
   localparam int BAUD            = 115_200;
   localparam int BIT_CYC         = CLK_HZ / BAUD;
   localparam int PPS_PERIOD_S    = 1;
   localparam int PPS_PERIOD_CYC  = CLK_HZ * PPS_PERIOD_S;
   localparam int PPS_HIGH_MS     = 100;
   localparam int PPS_HIGH_CYC    = (CLK_HZ / 1000) * PPS_HIGH_MS;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_TIME   = 8'h04;
   localparam logic [7:0] ADDR_MSEC   = 8'h08;
   localparam logic [7:0] ADDR_LAT    = 8'h0C;
   localparam logic [7:0] ADDR_LON    = 8'h10;
   localparam logic [7:0] ADDR_INFO   = 8'h14;
   localparam logic [7:0] ADDR_ALT    = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1C;

   // control bit positions and reset value
   localparam int CTRL_GGA_EN  = 0;
   localparam int CTRL_GLL_EN  = 1;
   localparam int CTRL_AUTO    = 2;
   localparam int CTRL_GO      = 3;
   localparam int CTRL_W       = 9;
   localparam logic [8:0] CTRL_RST = 9'h1F5;

   // info and altitude register field positions
   localparam int INFO_SOUTH = 4;
   localparam int INFO_WEST  = 5;
   localparam int INFO_QUAL  = 6;
   localparam int INFO_SATS  = 8;
   localparam int INFO_HDOP  = 16;
   localparam int INFO_VALID = 28;
   localparam int ALT_NEG    = 24;

   // sentence body lengths, dollar sign up to the last field
   localparam int GGA_LEN = 71;
   localparam int GLL_LEN = 46;
   localparam int TAIL_LEN = 5;
   localparam logic [7:0] SATS_MAX = 8'h16;

   // characters
   localparam logic [7:0] CH_SKIP  = 8'h00;
   localparam logic [7:0] CH_STAR  = 8'h2A;
   localparam logic [7:0] CH_CR    = 8'h0D;
   localparam logic [7:0] CH_LF    = 8'h0A;
   localparam logic [7:0] CH_MINUS = 8'h2D;
   localparam logic [7:0] CH_N     = 8'h4E;
   localparam logic [7:0] CH_S     = 8'h53;
   localparam logic [7:0] CH_E     = 8'h45;
   localparam logic [7:0] CH_W     = 8'h57;
   localparam logic [7:0] CH_A     = 8'h41;
   localparam logic [7:0] CH_V     = 8'h56;
   localparam logic [7:0] CH_ZERO  = 8'h30;

   typedef struct packed {
      logic [23:0] hms;
      logic [11:0] msec;
      logic [31:0] lat;
      logic [35:0] lon;
      logic        south;
      logic        west;
      logic [1:0]  qual;
      logic [7:0]  sats;
      logic [11:0] hdop;
      logic        valid;
      logic        alt_neg;
      logic [23:0] alt;
   } nfsf_fix_t;

   typedef enum logic [1:0] {ST_IDLE, ST_BODY, ST_TAIL} nfsf_state_t;
endpackage : nfsf_pkg

// File: hw/nfsf_uart_tx.sv
`timescale 1ns/10ps
module nfsf_uart_tx #(
   parameter int BIT_CYC = nfsf_pkg::BIT_CYC
) (
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output      logic       tx_ready,
   output      logic       txd
);
   localparam int CW = $clog2(BIT_CYC);

   logic [9:0]    shift_ff;
   logic [3:0]    bits_ff;
   logic [CW-1:0] baud_ff;

   assign tx_ready = (bits_ff == 4'h0);
   assign txd      = shift_ff[0];

   // start bit, eight data bits lsb first, one stop bit, no parity
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         shift_ff <= 10'h3FF;
         bits_ff  <= 4'h0;
         baud_ff  <= '0;
      end else if (tx_ready) begin
         if (tx_valid) begin
            shift_ff <= {1'b1, tx_data, 1'b0};
            bits_ff  <= 4'hA;
            baud_ff  <= '0;
         end
      end else if (baud_ff == CW'(BIT_CYC - 1)) begin
         baud_ff  <= '0;
         bits_ff  <= bits_ff - 4'h1;
         shift_ff <= {1'b1, shift_ff[9:1]};
      end else begin
         baud_ff <= baud_ff + CW'(1);
      end
   end
endmodule : nfsf_uart_tx

// File: sim/nfsf_formatter_sva.sv
`timescale 1ns/10ps
module nfsf_formatter_sva #(
   parameter int PPS_PERIOD_CYC = nfsf_pkg::PPS_PERIOD_CYC,
   parameter int PPS_HIGH_CYC   = nfsf_pkg::PPS_HIGH_CYC
) (
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        boot_rom_n,
   input wire logic        run_from_rom,
   input wire logic        second_time_mark_out,
   input wire logic        uart_txd
);
   logic [31:0] cyc_ff;
   logic [1:0]  rises_ff;
   logic        mark_ff;
   logic        mark_up;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   assign mark_up = second_time_mark_out & ~mark_ff;
   // cycles since last mark rise; first pulse skipped, its phase is free
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mark_ff  <= 1'b0;
         cyc_ff   <= 32'h0;
         rises_ff <= 2'h0;
      end else begin
         mark_ff <= second_time_mark_out;
         cyc_ff  <= mark_up ? 32'h1 : cyc_ff + 32'h1;
         if (mark_up && rises_ff != 2'h3)
            rises_ff <= rises_ff + 2'h1;
      end
   end
   a_mark_period: assert property (mark_up && rises_ff[1] |->
      cyc_ff == PPS_PERIOD_CYC) else $error("mark period wrong");
   a_mark_high: assert property ($fell(second_time_mark_out) &&
      rises_ff[1] |-> cyc_ff == PPS_HIGH_CYC) else $error("mark width wrong");
   a_rom_low: assert property ((!boot_rom_n)[*4] |-> run_from_rom)
      else $error("rom boot not seen");
   a_flash_high: assert property (boot_rom_n[*4] |-> !run_from_rom)
      else $error("flash boot not seen");
   a_bad_addr: assert property (psel && penable |->
      pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0)) else $error("slverr");
   a_zero_wait: assert property (psel && !penable |=> pready)
      else $error("pready low");
   a_unmapped_zero: assert property (psel && !penable && !pwrite &&
      paddr > 8'h1C |=> prdata == 32'h0) else $error("unmapped read data");
   a_start_bit: assert property ($fell(uart_txd) |=> !uart_txd [*8])
      else $error("start bit short");
   a_go_start: assert property (psel && penable && pwrite &&
      paddr == 8'h00 && pwdata[3] && pwdata[1:0] != 2'h0 && uart_txd |->
      ##[1:4] $fell(uart_txd)) else $error("sentence did not start");
   c_mark: cover property (mark_up);
   c_start: cover property ($fell(uart_txd));
   c_refused: cover property (psel && penable && pslverr);
endmodule : nfsf_formatter_sva

bind nfsf_formatter nfsf_formatter_sva #(.PPS_PERIOD_CYC(PPS_PERIOD_CYC),
   .PPS_HIGH_CYC(PPS_HIGH_CYC)) sva_u (.clk_sys(clk_sys), .nrst(nrst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .boot_rom_n(boot_rom_n), .run_from_rom(run_from_rom),
   .second_time_mark_out(second_time_mark_out), .uart_txd(uart_txd));

// File: sim/nfsf_host_rx.sv
`timescale 1ns/10ps
module nfsf_host_rx #(
   parameter int BIT_CYC = nfsf_pkg::BIT_CYC
) (
   input  wire logic       clk_sys,
   input  wire logic       rxd,
   output      logic       rx_stb,
   output      logic [7:0] rx_byte,
   output      logic       rx_ok
);
   logic [7:0] sh;
   logic       start_low;
   initial rx_stb = 1'b0;
   // eight data bits
   // mid-bit sampling, lsb first; start and stop levels both checked
   always begin
      @(negedge rxd);
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      start_low = !rxd;
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge clk_sys);
         sh[i] = rxd;
      end
      repeat (BIT_CYC) @(posedge clk_sys);
      rx_byte <= sh;
      rx_ok   <= start_low & rxd;
      rx_stb  <= 1'b1;
      @(posedge clk_sys);
      rx_stb  <= 1'b0;
   end
endmodule : nfsf_host_rx

// File: sim/nmea_fix_sentence_formatter_bench.sv
`timescale 1ns/10ps
module nmea_fix_sentence_formatter_bench;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        boot_rom_n = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] r;
   logic        pready, pslverr, run_from_rom, mark, uart_txd, err;
   logic        rx_stb, rx_ok;
   logic [7:0]  rx_byte;
   logic [7:0]  prev = 8'h0A;
   logic [7:0]  exp_q[$];
   logic [7:0]  s[$];
   nfsf_pkg::nfsf_fix_t f;
   int          mismatches = 0;
   int          checked = 0;
   int          cyc = 0;
   int          last = 0;
   localparam int BITC = 20; // short bit time keeps the run brief
   nfsf_formatter #(.PPS_PERIOD_CYC(20000), .PPS_HIGH_CYC(2000),
      .BIT_CYC(BITC)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .boot_rom_n(boot_rom_n), .run_from_rom(run_from_rom),
      .second_time_mark_out(mark), .uart_txd(uart_txd));
   nfsf_host_rx #(.BIT_CYC(BITC)) host_u (.clk_sys(clk_sys), .rxd(uart_txd),
      .rx_stb(rx_stb), .rx_byte(rx_byte), .rx_ok(rx_ok));
   // 125 MHz system clock
   always #4 clk_sys = ~clk_sys;
   task automatic chk(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // one apb transfer, then an idle edge so psel is never set twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb
   task automatic txt(input string t);
      foreach (t[i]) s.push_back(t[i]);
   endtask : txt
   task automatic digs(input logic [35:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) s.push_back(8'h30 + {4'h0, v[4*i+:4]});
   endtask : digs
   function automatic logic [7:0] hx(input logic [3:0] d);
      return (d < 4'hA) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
   endfunction : hx
   function automatic logic [35:0] rbcd(input int n);
      logic [35:0] v;
      v = '0;
      for (int i = 0; i < n; i++) v[4*i+:4] = 4'($urandom % 10);
      return v;
   endfunction : rbcd
   // dollar, body, star, checksum, line end
   task automatic frame();
      logic [7:0] x;
      x = 8'h00;
      foreach (s[i]) x ^= s[i];
      exp_q.push_back(8'h24);
      foreach (s[i]) exp_q.push_back(s[i]);
      exp_q = {exp_q, 8'h2A, hx(x[7:4]), hx(x[3:0]), 8'h0D, 8'h0A};
      s = {};
   endtask : frame
   task automatic pos();
      digs(f.lat[31:16], 4);
      txt(".");
      digs(f.lat[15:0], 4);
      txt(f.south ? ",S," : ",N,");
      digs(f.lon[35:16], 5);
      txt(".");
      digs(f.lon[15:0], 4);
      txt(f.west ? ",W" : ",E");
   endtask : pos
   task automatic tm();
      digs(f.hms, 6);
      txt(".");
      digs(f.msec, 3);
   endtask : tm
   // expected sentences noted first, then fix loaded and sending started
   task automatic run(input string name);
      logic lead;
      lead = 1'b0;
      txt("GPGGA,");
      tm();
      txt(",");
      pos();
      txt(",");
      s.push_back(f.qual == 2'h3 ? 8'h30 : 8'h30 + {6'h0, f.qual});
      txt(",");
      digs(f.sats > 8'h16 ? 8'h16 : f.sats, 2);
      txt(",");
      digs(f.hdop[11:4], 2);
      txt(".");
      digs(f.hdop[3:0], 1);
      txt(f.alt_neg ? ",-" : ",");
      for (int i = 5; i > 0; i--) if (lead || i == 1 || f.alt[4*i+:4]) begin
         lead = 1'b1;
         digs(f.alt[4*i+:4], 1);
      end
      txt(".");
      digs(f.alt[3:0], 1);
      txt(",M,,,,0000");
      frame();
      txt("GPGLL,");
      pos();
      txt(",");
      tm();
      txt(f.valid ? ",A,A" : ",V,V");
      frame();
      apb(1'b1, 8'h04, {8'h0, f.hms});
      apb(1'b1, 8'h08, {20'h0, f.msec});
      apb(1'b1, 8'h0C, f.lat);
      apb(1'b1, 8'h10, f.lon[31:0]);
      apb(1'b1, 8'h14, {3'h0, f.valid, f.hdop, f.sats, f.qual, f.west,
         f.south, f.lon[35:32]});
      apb(1'b1, 8'h18, {7'h0, f.alt_neg, f.alt});
      apb(1'b0, 8'h18, 32'h0);
      chk("alt readback", r, {7'h0, f.alt_neg, f.alt});
      apb(1'b1, 8'h00, 32'h0000_01FB);
      while (exp_q.size() != 0) @(posedge clk_sys);
      repeat (1500) @(posedge clk_sys);
      $display("test %s done", name);
   endtask : run
   // serial watcher: each received byte against the oldest note
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (rx_stb) begin
         chk("frame bits", {31'h0, rx_ok}, 32'h1);
         if (prev != 8'h0A)
            chk("byte gap", {31'h0, cyc - last <= 10*BITC+4}, 32'h1);
         if (exp_q.size() == 0)
            chk("spare byte", {24'h0, rx_byte}, 32'hFFFF_FFFF);
         else
            chk("byte", {24'h0, rx_byte}, {24'h0, exp_q.pop_front()});
         last <= cyc;
         prev <= rx_byte;
      end
   end
   task automatic close_out();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   // hang guard, well past both sentence pairs of serial time
   initial begin
      repeat (90_000) @(posedge clk_sys);
      mismatches++;
      close_out();
   end
   initial begin
      void'($urandom(32'h168CC84F));
      f = '0;
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl reset", r, 32'h0000_01F5);
      // auto off early so no sentence starts on a second tick
      apb(1'b1, 8'h00, 32'h0000_01F0);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", {r[30:0], err}, 32'h1);
      apb(1'b1, 8'h1E, 32'hFFFF_FFFF);
      chk("misaligned", {31'h0, err}, 32'h1);
      boot_rom_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      apb(1'b0, 8'h1C, 32'h0);
      chk("rom boot", {r[31:1], run_from_rom}, 32'h3);
      boot_rom_n <= 1'b1;
      repeat (4000) @(posedge clk_sys);
      chk("flash boot", {31'h0, run_from_rom}, 32'h0);
      $display("test setup done");
      f.lat = 32'(rbcd(8));
      f.lon = rbcd(9);
      {f.qual, f.sats, f.hdop, f.valid, f.alt} = {2'h2, 8'h23, 12'h999,
         1'b1, 24'h179999};
      run("upper bounds");
      f.lat = 32'(rbcd(7));
      f.lon = rbcd(8);
      {f.hms, f.msec, f.south, f.west} = {24'h235959, 12'h999, 2'b11};
      {f.qual, f.sats, f.hdop, f.valid} = {2'h0, 8'h00, 12'h000, 1'b0};
      {f.alt_neg, f.alt} = {1'b1, 24'h000123};
      run("lower bounds");
      apb(1'b0, 8'h1C, 32'h0);
      chk("sentence count", r, 32'h0000_0400);
      close_out();
   end
endmodule : nmea_fix_sentence_formatter_bench
